/* File: design/dfm_pkg.sv */
// dfm_pkg: constants shared by the drive fault manager files
// assumes a 200 MHz clock and a classic wishbone register slave
package dfm_pkg;
  // ************
  // register map
  // ************
  localparam logic [7:0] DFM_CFG_OFS = 8'h00;
  localparam logic [7:0] DFM_CMD_OFS = 8'h04;
  localparam logic [7:0] DFM_STAT_OFS = 8'h08;
  localparam logic [7:0] DFM_HIST_OFS = 8'h0c;
  localparam logic [7:0] DFM_IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] DFM_IRQ_MASK_OFS = 8'h14;
  // cfg fields
  localparam int DFM_CFG_LIMIT_LSB = 0;
  localparam int DFM_CFG_STOP_LSB = 4;
  localparam int DFM_CFG_DIN1_LSB = 8;
  localparam int DFM_CFG_DIN2_LSB = 13;
  localparam int DFM_CFG_DELAY_LSB = 18;
  localparam logic [31:0] DFM_CFG_RST = 32'h0000_0000;
  // clear command values
  localparam logic [1:0] DFM_CMD_IDLE = 2'h0;
  localparam logic [1:0] DFM_CMD_RESET = 2'h1;
  localparam logic [1:0] DFM_CMD_CLEAR_HIST = 2'h2;
  localparam logic [4:0] DFM_DIN_CLEAR_FAULT = 5'h07;
  localparam logic [2:0] DFM_STOP_CLEAR_MAX = 3'h3;
  // fault codes
  localparam logic [7:0] DFM_NO_FAULT = 8'h00;
  localparam logic [7:0] DFM_UNDERVOLT = 8'h04;
  localparam logic [7:0] DFM_BUS_OVERVOLTAGE_FAULT = 8'h05;
  localparam logic [7:0] DFM_HEATSINK_FAULT = 8'h08;
  localparam logic [7:0] DFM_RESTART_EXHAUSTED_FAULT = 8'h21;
  // interrupt bits
  localparam int DFM_IRQ_FAULT = 0;
  localparam int DFM_IRQ_AUTOCLR = 1;
  localparam int DFM_IRQ_EXHAUST = 2;
  localparam int DFM_IRQ_W = 3;
  // timing: delay setting unit is 0.1 s
  localparam int DFM_CLK_HZ = 200_000_000;
  localparam int DFM_DELAY_UNIT_MS = 100;
  localparam int DFM_TICK_CYC = DFM_CLK_HZ / 1000 * DFM_DELAY_UNIT_MS;
  localparam int DFM_FLASH_MS = 500;
  localparam int DFM_FLASH_TICKS = DFM_FLASH_MS / DFM_DELAY_UNIT_MS;
  localparam int DFM_HIST_DEPTH = 3;
endpackage : dfm_pkg

/* File: design/dfm_tick_div.sv */
// dfm_tick_div: divider giving a one-cycle enable every DIV cycles
// assumes a single clock and synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module dfm_tick_div #(
  parameter int DIV = 20_000_000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);
  logic [31:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || cnt_q == 32'(DIV - 1)) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    tick_o <= !rst_i && cnt_q == 32'(DIV - 1);
  end
endmodule // dfm_tick_div
`default_nettype wire

/* File: design/dfm_top.sv */
// dfm_top: drive fault manager with wishbone registers and irq
// assumes fault detectors give a code and a live cause level
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module dfm_top
  import dfm_pkg::*;
#(
  parameter int TICK_CYC = DFM_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic fault_raise_i,
  input wire logic [7:0] fault_code_i,
  input wire logic fault_class2_i,
  input wire logic cause_present_i,
  input wire logic stop_key_i,
  input wire logic esc_key_i,
  input wire logic din1_i,
  input wire logic din2_i,
  output logic drive_halt_o,
  output logic auto_start_o,
  output logic [7:0] disp_code_o,
  output logic disp_on_o,
  output logic fault_led_o,
  output logic irq_o
);
  // ************
  // state
  // ************
  typedef enum logic [3:0] {
    DFM_IDLE = 4'b0001,
    DFM_FAULT = 4'b0010,
    DFM_WAIT = 4'b0100,
    DFM_TRY = 4'b1000
  } dfm_state_t;

  dfm_state_t state_q;
  logic [31:0] cfg_q;
  logic [7:0] code_q;
  logic class2_q;
  logic acked_q;
  logic [7:0] hist_q [DFM_HIST_DEPTH];
  logic [13:0] delay_cnt_q;
  logic [3:0] tries_q;
  logic [DFM_IRQ_W-1:0] irq_stat_q;
  logic [DFM_IRQ_W-1:0] irq_mask_q;
  logic [DFM_IRQ_W-1:0] irq_set;
  logic din1_q, din2_q, flash_q;
  logic [3:0] flash_cnt_q;
  logic tick;
  logic wr, rd_ack_d, cmd_wr, clear_req, auto_clr, auto_fail, hist_clr;
  logic [31:0] rd_d;
  wire class2_in = fault_class2_i
    && fault_code_i != DFM_BUS_OVERVOLTAGE_FAULT;

  wire [3:0] limit = cfg_q[DFM_CFG_LIMIT_LSB +: 4];
  wire [2:0] stop_sel = cfg_q[DFM_CFG_STOP_LSB +: 3];
  wire [4:0] din1_fn = cfg_q[DFM_CFG_DIN1_LSB +: 5];
  wire [4:0] din2_fn = cfg_q[DFM_CFG_DIN2_LSB +: 5];
  wire [13:0] delay_set = cfg_q[DFM_CFG_DELAY_LSB +: 14];

  function automatic logic no_run_class(input logic [7:0] c);
    no_run_class = c == DFM_BUS_OVERVOLTAGE_FAULT || c == DFM_UNDERVOLT
      || c == DFM_HEATSINK_FAULT;
  endfunction

  dfm_tick_div #(.DIV(TICK_CYC)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  // ************
  // wishbone slave
  // ************
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign cmd_wr = wr && wb_adr_i == DFM_CMD_OFS && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    if (wb_adr_i == DFM_CFG_OFS) begin
      rd_d = cfg_q;
    end else if (wb_adr_i == DFM_STAT_OFS) begin
      rd_d = {16'h0000, tries_q, acked_q, class2_q,
        state_q != DFM_IDLE, 1'b0, code_q};
    end else if (wb_adr_i == DFM_HIST_OFS) begin
      rd_d = {8'h00, hist_q[2], hist_q[1], hist_q[0]};
    end else if (wb_adr_i == DFM_IRQ_STAT_OFS) begin
      rd_d = {29'h0, irq_stat_q};
    end else if (wb_adr_i == DFM_IRQ_MASK_OFS) begin
      rd_d = {29'h0, irq_mask_q};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= rd_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= DFM_CFG_RST;
    end else if (wr && wb_adr_i == DFM_CFG_OFS) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          cfg_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
    end
  end

  // ************
  // clear sources
  // ************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      din1_q <= 1'b0;
      din2_q <= 1'b0;
    end else begin
      din1_q <= din1_i;
      din2_q <= din2_i;
    end
  end

  // power cycle is rst_i itself, which empties the fault state
  always_comb begin
    clear_req = 1'b0;
    if (stop_key_i && stop_sel <= DFM_STOP_CLEAR_MAX) begin
      clear_req = 1'b1;
    end else if (cmd_wr && wb_dat_i[1:0] != DFM_CMD_IDLE) begin
      clear_req = wb_dat_i[1:0] == DFM_CMD_RESET
        || wb_dat_i[1:0] == DFM_CMD_CLEAR_HIST;
    end else if (din1_fn == DFM_DIN_CLEAR_FAULT && din1_i != din1_q) begin
      clear_req = 1'b1;
    end else if (din2_fn == DFM_DIN_CLEAR_FAULT && din2_i != din2_q) begin
      clear_req = 1'b1;
    end
  end
  assign hist_clr = cmd_wr && wb_dat_i[1:0] == DFM_CMD_CLEAR_HIST;

  // ************
  // fault state machine
  // ************
  assign auto_clr = state_q == DFM_TRY && !cause_present_i;
  assign auto_fail = state_q == DFM_TRY && cause_present_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= DFM_IDLE;
      code_q <= DFM_NO_FAULT;
      class2_q <= 1'b0;
      tries_q <= 4'h0;
      delay_cnt_q <= 14'h0;
      auto_start_o <= 1'b0;
    end else begin
      auto_start_o <= 1'b0;
      case (state_q)
        DFM_IDLE: begin
          if (fault_raise_i) begin
            code_q <= fault_code_i;
            class2_q <= class2_in;
            delay_cnt_q <= delay_set;
            if (!class2_in && limit != 4'h0) begin
              state_q <= DFM_WAIT;
            end else begin
              state_q <= DFM_FAULT;
            end
          end
        end
        DFM_WAIT: begin
          if (clear_req && !cause_present_i) begin
            state_q <= DFM_IDLE;
            tries_q <= 4'h0;
          end else if (delay_cnt_q == 14'h0) begin
            state_q <= DFM_TRY;
          end else if (tick) begin
            delay_cnt_q <= delay_cnt_q - 14'h1;
          end
        end
        DFM_TRY: begin
          if (auto_clr) begin
            state_q <= DFM_IDLE;
            tries_q <= 4'h0;
            // zero delay only clears these, motor stays stopped
            auto_start_o <= !(delay_set == 14'h0
              && no_run_class(code_q));
          end else if (tries_q + 4'h1 >= limit) begin
            code_q <= DFM_RESTART_EXHAUSTED_FAULT;
            class2_q <= 1'b1;
            state_q <= DFM_FAULT;
          end else begin
            tries_q <= tries_q + 4'h1;
            delay_cnt_q <= delay_set;
            state_q <= DFM_WAIT;
          end
        end
        default: begin
          if (clear_req && !cause_present_i) begin
            state_q <= DFM_IDLE;
            tries_q <= 4'h0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_halt_o <= 1'b0;
    end else begin
      drive_halt_o <= state_q != DFM_IDLE || fault_raise_i;
    end
  end

  // ************
  // history
  // ************
  always_ff @(posedge clk_i) begin
    if (rst_i || hist_clr) begin
      for (int i = 0; i < DFM_HIST_DEPTH; i++) begin
        hist_q[i] <= DFM_NO_FAULT;
      end
    end else if (state_q == DFM_IDLE && fault_raise_i) begin
      hist_q[0] <= fault_code_i;
      for (int i = 1; i < DFM_HIST_DEPTH; i++) begin
        hist_q[i] <= hist_q[i-1];
      end
    end else if (state_q == DFM_TRY && auto_fail
                 && tries_q + 4'h1 >= limit) begin
      hist_q[0] <= DFM_RESTART_EXHAUSTED_FAULT;
      for (int i = 1; i < DFM_HIST_DEPTH; i++) begin
        hist_q[i] <= hist_q[i-1];
      end
    end
  end

  // ************
  // keypad display
  // ************
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q == DFM_IDLE) begin
      acked_q <= 1'b0;
    end else if (esc_key_i) begin
      acked_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_cnt_q <= 4'h0;
      flash_q <= 1'b0;
    end else if (tick) begin
      if (flash_cnt_q == 4'(DFM_FLASH_TICKS - 1)) begin
        flash_cnt_q <= 4'h0;
        flash_q <= !flash_q;
      end else begin
        flash_cnt_q <= flash_cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      disp_code_o <= DFM_NO_FAULT;
      disp_on_o <= 1'b0;
      fault_led_o <= 1'b0;
    end else begin
      disp_code_o <= code_q;
      disp_on_o <= state_q != DFM_IDLE && !acked_q && flash_q;
      fault_led_o <= state_q != DFM_IDLE && flash_q;
    end
  end

  // ************
  // interrupts
  // ************
  assign irq_set = {auto_fail && tries_q + 4'h1 >= limit, auto_clr,
    state_q == DFM_IDLE && fault_raise_i};

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      if (wr && wb_adr_i == DFM_IRQ_MASK_OFS && wb_sel_i[0]) begin
        irq_mask_q <= wb_dat_i[DFM_IRQ_W-1:0];
      end
      if (wr && wb_adr_i == DFM_IRQ_STAT_OFS && wb_sel_i[0]) begin
        irq_stat_q <= (irq_stat_q & ~wb_dat_i[DFM_IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end
endmodule // dfm_top
`default_nettype wire

/* File: tb/dfm_panel.sv */
// dfm_panel: keypad and control input model for the fault manager
// assumes the bench asks for each key press one cycle wide
`timescale 1ns/10ps
`default_nettype none
module dfm_panel (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stop_req_i,
  input wire logic esc_req_i,
  input wire logic [1:0] din_req_i,
  output logic stop_key_o,
  output logic esc_key_o,
  output logic din1_o,
  output logic din2_o
);
  // keys are pulses; inputs are levels held until toggled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {stop_key_o, esc_key_o, din1_o, din2_o} <= 4'h0;
    end else begin
      stop_key_o <= stop_req_i;
      esc_key_o <= esc_req_i;
      din1_o <= din1_o ^ din_req_i[0];
      din2_o <= din2_o ^ din_req_i[1];
    end
  end
endmodule // dfm_panel
`default_nettype wire

/* File: tb/dfm_top_monitor.sv */
// dfm_top_monitor: port checks for the drive fault manager
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module dfm_mon
  import dfm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fault_raise_i,
  input wire logic [7:0] fault_code_i,
  input wire logic fault_class2_i,
  input wire logic cause_present_i,
  input wire logic esc_key_i,
  input wire logic drive_halt_o,
  input wire logic auto_start_o,
  input wire logic [7:0] disp_code_o,
  input wire logic disp_on_o,
  input wire logic fault_led_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // **********
  // properties
  // **********
  // raise only counts from idle: the raise cycle may already show halt
  property p_halt;
    $rose(fault_raise_i) && !$past(drive_halt_o) |=> drive_halt_o;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt");
  property p_refuse;
    drive_halt_o && cause_present_i |=> drive_halt_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("cleared");
  property p_noauto;
    $rose(fault_raise_i) && fault_class2_i && !$past(drive_halt_o)
      && fault_code_i != DFM_BUS_OVERVOLTAGE_FAULT |=> !auto_start_o [*8];
  endproperty
  a_noauto: assert property (p_noauto) else $error("auto start");
  property p_start;
    auto_start_o && !fault_raise_i |-> ##[0:1] !drive_halt_o;
  endproperty
  a_start: assert property (p_start) else $error("start halted");
  property p_pulse;
    auto_start_o |-> $past(drive_halt_o) ##1 !auto_start_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse");
  property p_esc;
    esc_key_i && drive_halt_o && cause_present_i |-> ##2 !disp_on_o [*8];
  endproperty
  a_esc: assert property (p_esc) else $error("esc ignored");
  property p_code;
    $rose(fault_raise_i) && !$past(drive_halt_o)
      |=> ##1 disp_code_o == $past(fault_code_i, 2);
  endproperty
  a_code: assert property (p_code) else $error("code");
  property p_dark;
    !drive_halt_o && !$past(drive_halt_o) |-> !fault_led_o && !disp_on_o;
  endproperty
  a_dark: assert property (p_dark) else $error("lit idle");
endmodule // dfm_mon
bind dfm_top dfm_mon u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .fault_raise_i(fault_raise_i),
  .fault_code_i(fault_code_i), .fault_class2_i(fault_class2_i),
  .cause_present_i(cause_present_i), .esc_key_i(esc_key_i),
  .drive_halt_o(drive_halt_o), .auto_start_o(auto_start_o),
  .disp_code_o(disp_code_o), .disp_on_o(disp_on_o),
  .fault_led_o(fault_led_o)
);
`default_nettype wire

/* File: tb/dfm_top_test.sv */
// dfm_top_test: self-checking bench for the drive fault manager
// assumes dfm_top with a short tick, the panel model and the monitor
`timescale 1ns/10ps
`default_nettype none
module dfm_top_test;
  import dfm_pkg::*;
  localparam int TK = 10;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, drive_halt_o, auto_start_o, disp_on_o, fault_led_o, irq_o;
  logic [7:0] disp_code_o;
  logic fault_raise_i = 1'b0, fault_class2_i = 1'b0, cause_present_i = 1'b0;
  logic [7:0] fault_code_i = 8'h00;
  logic stop_req = 1'b0, esc_req = 1'b0, stop_key, esc_key, din1, din2, pi;
  logic [1:0] din_req = 2'h0;
  int fails = 0, n_tests = 0, starts, tg, dly;
  always #2.5 clk_i = ~clk_i;
  dfm_top #(.TICK_CYC(TK)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .fault_raise_i(fault_raise_i), .fault_code_i(fault_code_i),
    .fault_class2_i(fault_class2_i), .cause_present_i(cause_present_i),
    .stop_key_i(stop_key), .esc_key_i(esc_key), .din1_i(din1), .din2_i(din2),
    .drive_halt_o(drive_halt_o), .auto_start_o(auto_start_o),
    .disp_code_o(disp_code_o), .disp_on_o(disp_on_o),
    .fault_led_o(fault_led_o), .irq_o(irq_o)
  );
  dfm_panel u_panel (
    .clk_i(clk_i), .rst_i(rst_i), .stop_req_i(stop_req), .esc_req_i(esc_req),
    .din_req_i(din_req), .stop_key_o(stop_key), .esc_key_o(esc_key),
    .din1_o(din1), .din2_o(din2)
  );
  // *****
  // tasks
  // *****
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // classic cycle; waits for ack however long the slave takes
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic cfg(input int lim, input int stp, input int dl);
    wb(DFM_CFG_OFS, 1'b1, (32'(lim) << DFM_CFG_LIMIT_LSB) |
      (32'(stp) << DFM_CFG_STOP_LSB) | (32'h7 << DFM_CFG_DIN2_LSB) |
      (32'(dl) << DFM_CFG_DELAY_LSB));
  endtask
  task automatic raise(input logic [7:0] c, input logic c2, input logic cz);
    fault_code_i <= c;
    fault_class2_i <= c2;
    cause_present_i <= cz;
    fault_raise_i <= 1'b1;
    @(posedge clk_i);
    fault_raise_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    starts = 0;
    while (drive_halt_o !== 1'b0 && n < lim) begin
      @(posedge clk_i);
      n++;
      if (auto_start_o === 1'b1) starts++;
    end
    repeat (3) begin
      @(posedge clk_i);
      if (auto_start_o === 1'b1) starts++;
    end
  endtask
  // k: 0 stop key, 1 escape key, 2 toggle input two, 3 toggle input one
  task automatic press(input int k);
    stop_req <= (k == 0);
    esc_req <= (k == 1);
    din_req <= (k == 2) ? 2'h2 : (k == 3) ? 2'h1 : 2'h0;
    @(posedge clk_i);
    stop_req <= 1'b0;
    esc_req <= 1'b0;
    din_req <= 2'h0;
    repeat (3) @(posedge clk_i);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    stop_test;
  end
  initial begin
    logic [7:0] cd [3];
    cd = '{DFM_UNDERVOLT, DFM_BUS_OVERVOLTAGE_FAULT, DFM_HEATSINK_FAULT};
    void'($urandom(67));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(DFM_CFG_OFS, 1'b0, 32'h0);
    chk(q, DFM_CFG_RST);
    wb(8'h40, 1'b1, 32'hffff_ffff);
    wb(8'h40, 1'b0, 32'h0);
    chk(q, 32'h0);
    $display("test reset done");
    // code 5 raised flagged class 2 must still auto clear
    for (int i = 0; i < 6; i++) begin
      dly = (i < 3) ? 0 : 1 + $urandom % 3;
      cfg(1 + $urandom % 15, 4, dly);
      raise(cd[i % 3], cd[i % 3] == DFM_BUS_OVERVOLTAGE_FAULT, 1'b0);
      wait_idle(TK * 5 + 50);
      chk(drive_halt_o, 1'b0);
      chk(32'(starts), dly != 0);
      wb(DFM_HIST_OFS, 1'b0, 32'h0);
      chk(q[7:0], cd[i % 3]);
      wb(DFM_STAT_OFS, 1'b0, 32'h0);
      chk({q[15:12], q[9]}, 5'h0);
    end
    $display("test auto done");
    cfg(1, 3, 1);
    raise(8'h06, 1'b0, 1'b1);
    repeat (TK * 8) @(posedge clk_i);
    wb(DFM_STAT_OFS, 1'b0, 32'h0);
    chk({q[10:9], q[7:0]}, {2'b11, DFM_RESTART_EXHAUSTED_FAULT});
    press(0);
    chk(drive_halt_o, 1'b1);
    cause_present_i <= 1'b0;
    press(0);
    wait_idle(20);
    chk(drive_halt_o, 1'b0);
    $display("test exhausted done");
    cfg(3, 4, 1);
    raise(8'h0c + 8'($urandom % 4), 1'b1, 1'b1);
    tg = 0;
    repeat (TK * 12) begin
      @(posedge clk_i);
      tg += (fault_led_o === 1'b1);
    end
    chk(tg > 0 && tg < TK * 12, 1'b1);
    chk(drive_halt_o, 1'b1);
    press(1);
    chk({drive_halt_o, disp_on_o}, 2'b10);
    cause_present_i <= 1'b0;
    press(0);
    chk(drive_halt_o, 1'b1);
    press(3);
    chk(drive_halt_o, 1'b1);
    press(2);
    wait_idle(20);
    chk(drive_halt_o, 1'b0);
    for (int k = 1; k < 3; k++) begin
      raise(8'h0d, 1'b1, 1'b0);
      wb(DFM_CMD_OFS, 1'b1, 32'(k));
      wait_idle(20);
      chk(drive_halt_o, 1'b0);
      wb(DFM_HIST_OFS, 1'b0, 32'h0);
      chk(q[7:0] === 8'h0d, k == 1);
    end
    $display("test clear done");
    wb(DFM_IRQ_STAT_OFS, 1'b0, 32'h0);
    chk(q[2:0], 3'h7);
    wb(DFM_IRQ_MASK_OFS, 1'b1, 32'h0);
    pi = irq_o;
    wb(DFM_IRQ_MASK_OFS, 1'b1, 32'h7);
    chk(pi ^ irq_o, 1'b1);
    wb(DFM_IRQ_STAT_OFS, 1'b1, 32'h7);
    chk(irq_o, 1'b0);
    raise(8'h0d, 1'b1, 1'b1);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(drive_halt_o, 1'b0);
    $display("test irq and power done");
    stop_test;
  end
endmodule // dfm_top_test
`default_nettype wire
